// file: rtl/refclk_pkg.sv
// Package: register map, field layout and reset values of the reference clock and summary block
`default_nettype none
package refclk_pkg;
   localparam int          ADDR_W            = 12;
   localparam int          NUM_CHAN          = 17;
   localparam int          STATUS_W          = 8;
   localparam logic [11:0] OFS_SUMMARY_LOW   = 12'h2c0;
   localparam logic [11:0] OFS_SUMMARY_HIGH  = 12'h300;
   localparam logic [11:0] OFS_REF_CONTROL   = 12'h020;
   localparam int          POS_REF_ENABLE    = 6;
   localparam int          POS_RATE_SELECT   = 5;
   localparam int          POS_SOURCE_LSB    = 0;
   localparam int          SOURCE_W          = 5;
   localparam logic        RST_REF_ENABLE    = 1'b1;
   localparam logic        RST_RATE_SELECT   = 1'b0;
   localparam logic [4:0]  RST_SOURCE        = 5'h01;
   localparam logic [7:0]  RST_SUMMARY       = 8'h00;
   localparam int          LOW_FIRST_CHAN    = 1;
   localparam int          HIGH_FIRST_CHAN   = 9;

   typedef struct packed {
      logic       ref_out_enable;
      logic       aux_clock_rate_select;
      logic [4:0] ref_source_select;
   } ref_control_t;
endpackage : refclk_pkg
`default_nettype wire

// file: rtl/refclk_select_and_irq_summary.sv
// Reference clock select, aux clock rate bit and per-channel interrupt summary with Wishbone slave
// Behaviour
// - Enable bit 0 leaves reference output undriven, output enable low.
// - Enable bit 1 drives selected clock on the pin; enable resets to 1.
// - Rate bit 0 means T1 on aux clock input, 1 means E1; resets 0.
// - Five-bit source code picks channel recovered clock, binary; resets to 00001.
// - Low summary register bit 7..0 shows channels 8..1.
// - High summary register bit 7..0 shows channels 16..9.
// - Summary bit reads 1 while channel has a pending interrupt, else 0.
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
module refclk_select_and_irq_summary #(
   parameter int STATUS_W = refclk_pkg::STATUS_W
) (
   input  wire logic                                    CLOCK,
   input  wire logic                                    SYS_RST,
   input  wire logic [refclk_pkg::ADDR_W-1:0]           WB_ADR_I,
   input  wire logic [31:0]                             WB_DAT_I,
   input  wire logic [3:0]                              WB_SEL_I,
   input  wire logic                                    WB_WE_I,
   input  wire logic                                    WB_CYC_I,
   input  wire logic                                    WB_STB_I,
   output logic      [31:0]                             WB_DAT_O,
   output logic                                         WB_ACK_O,
   input  wire logic [refclk_pkg::NUM_CHAN-1:0]         RECOVERED_CLOCKS,
   input  wire logic [refclk_pkg::NUM_CHAN*STATUS_W-1:0] CHAN_IRQ_STATUS,
   output logic                                         REFERENCE_CLOCK_OUTPUT_O,
   output logic                                         REFERENCE_CLOCK_OUTPUT_OE,
   output logic                                         AUX_CLOCK_RATE_SELECT
);
   refclk_pkg::ref_control_t ctrl_reg;
   logic [7:0]               summary_low_reg;
   logic [7:0]               summary_high_reg;
   logic [refclk_pkg::NUM_CHAN-1:0] clk_s1_reg;
   logic [refclk_pkg::NUM_CHAN-1:0] clk_s2_reg;
   logic [refclk_pkg::NUM_CHAN-1:0] clk_s3_reg;
   logic [refclk_pkg::NUM_CHAN-1:0] clk_stable_reg;
   logic [refclk_pkg::NUM_CHAN-1:0] pending;
   logic                     access;
   logic                     selected;
   logic [31:0]              read_next;

   assign access = WB_CYC_I && WB_STB_I && !WB_ACK_O;

   // Three-stage sampling; change accepted once stages two and three agree
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         clk_s1_reg     <= '0;
         clk_s2_reg     <= '0;
         clk_s3_reg     <= '0;
         clk_stable_reg <= '0;
      end else begin
         clk_s1_reg <= RECOVERED_CLOCKS;
         clk_s2_reg <= clk_s1_reg;
         clk_s3_reg <= clk_s2_reg;
         for (int i = 0; i < refclk_pkg::NUM_CHAN; i++) begin
            if (clk_s2_reg[i] == clk_s3_reg[i]) begin
               clk_stable_reg[i] <= clk_s3_reg[i];
            end
         end
      end
   end

   // Per-channel OR of status bits
   for (genvar ch = 0; ch < refclk_pkg::NUM_CHAN; ch++) begin : g_pending
      assign pending[ch] = |CHAN_IRQ_STATUS[ch*STATUS_W +: STATUS_W];
   end

   // Registered every cycle so a cleared source drops its bit without a write
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         summary_low_reg  <= refclk_pkg::RST_SUMMARY;
         summary_high_reg <= refclk_pkg::RST_SUMMARY;
      end else begin
         summary_low_reg  <= pending[refclk_pkg::LOW_FIRST_CHAN +: 8];
         summary_high_reg <= pending[refclk_pkg::HIGH_FIRST_CHAN +: 8];
      end
   end

   // Control register writes, lane 0 only
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ctrl_reg.ref_out_enable        <= refclk_pkg::RST_REF_ENABLE;
         ctrl_reg.aux_clock_rate_select <= refclk_pkg::RST_RATE_SELECT;
         ctrl_reg.ref_source_select     <= refclk_pkg::RST_SOURCE;
      end else if (access && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == refclk_pkg::OFS_REF_CONTROL) begin
         ctrl_reg.ref_out_enable        <= WB_DAT_I[refclk_pkg::POS_REF_ENABLE];
         ctrl_reg.aux_clock_rate_select <= WB_DAT_I[refclk_pkg::POS_RATE_SELECT];
         ctrl_reg.ref_source_select     <= WB_DAT_I[refclk_pkg::POS_SOURCE_LSB +: refclk_pkg::SOURCE_W];
      end
   end

   // Summary registers ignore writes; their content follows the sources
   always_comb begin
      read_next = 32'h0000_0000;
      unique case (WB_ADR_I)
         refclk_pkg::OFS_REF_CONTROL:  read_next[7:0] = {1'b0, ctrl_reg};
         refclk_pkg::OFS_SUMMARY_LOW:  read_next[7:0] = summary_low_reg;
         refclk_pkg::OFS_SUMMARY_HIGH: read_next[7:0] = summary_high_reg;
         default:                      read_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else begin
         WB_ACK_O <= access;
         if (access) begin
            WB_DAT_O <= read_next;
         end
      end
   end

   // Codes above the last channel select nothing and drive low
   always_comb begin
      selected = 1'b0;
      if (ctrl_reg.ref_source_select < 5'(refclk_pkg::NUM_CHAN)) begin
         selected = clk_stable_reg[ctrl_reg.ref_source_select];
      end
   end

   // Clock is resampled at 25 MHz, so only slow line clocks pass cleanly
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         REFERENCE_CLOCK_OUTPUT_O  <= 1'b0;
         REFERENCE_CLOCK_OUTPUT_OE <= 1'b0;
         AUX_CLOCK_RATE_SELECT     <= refclk_pkg::RST_RATE_SELECT;
      end else begin
         REFERENCE_CLOCK_OUTPUT_OE <= ctrl_reg.ref_out_enable;
         REFERENCE_CLOCK_OUTPUT_O  <= ctrl_reg.ref_out_enable ? selected : 1'b0;
         AUX_CLOCK_RATE_SELECT     <= ctrl_reg.aux_clock_rate_select;
      end
   end
endmodule : refclk_select_and_irq_summary
`default_nettype wire

// file: tb/refclk_checker.sv
// Port assertions of the reference clock and summary block
`default_nettype none
module refclk_checker #(parameter int STATUS_W = 8) (
   input wire logic                   CLOCK,
   input wire logic                   SYS_RST,
   input wire logic [11:0]            WB_ADR_I,
   input wire logic                   WB_WE_I,
   input wire logic                   WB_CYC_I,
   input wire logic                   WB_STB_I,
   input wire logic [31:0]            WB_DAT_O,
   input wire logic                   WB_ACK_O,
   input wire logic [17*STATUS_W-1:0] CHAN_IRQ_STATUS,
   input wire logic                   REFERENCE_CLOCK_OUTPUT_O,
   input wire logic                   REFERENCE_CLOCK_OUTPUT_OE,
   input wire logic                   AUX_CLOCK_RATE_SELECT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] lo, hi;
   wire        rq = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         lo[i] = |CHAN_IRQ_STATUS[(i+1)*STATUS_W +: STATUS_W];
         hi[i] = |CHAN_IRQ_STATUS[(i+9)*STATUS_W +: STATUS_W];
      end
   end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (SYS_RST);
   property p_ack; rq |=> WB_ACK_O; endproperty
   a_ack: assert property (p_ack) else $error("request not acknowledged");
   property p_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   property p_cause; WB_ACK_O |-> $past(rq); endproperty
   a_cause: assert property (p_cause) else $error("ack without request");
   property p_hiz; !REFERENCE_CLOCK_OUTPUT_OE |-> !REFERENCE_CLOCK_OUTPUT_O; endproperty
   a_hiz: assert property (p_hiz) else $error("pin data while disabled");
   property p_en; $fell(SYS_RST) |=> REFERENCE_CLOCK_OUTPUT_OE; endproperty
   a_en: assert property (p_en) else $error("output not enabled after reset");
   property p_rate; $fell(SYS_RST) |-> !AUX_CLOCK_RATE_SELECT; endproperty
   a_rate: assert property (p_rate) else $error("rate bit not cleared by reset");
   // Summary lags status one cycle, so status must be steady
   property p_lo; rq && !WB_WE_I && WB_ADR_I == 12'h2c0 && $stable(CHAN_IRQ_STATUS) && !$past(SYS_RST)
      |=> WB_DAT_O == {24'h0, $past(lo)}; endproperty
   a_lo: assert property (p_lo) else $error("low summary wrong");
   property p_hi; rq && !WB_WE_I && WB_ADR_I == 12'h300 && $stable(CHAN_IRQ_STATUS) && !$past(SYS_RST)
      |=> WB_DAT_O == {24'h0, $past(hi)}; endproperty
   a_hi: assert property (p_hi) else $error("high summary wrong");
endmodule : refclk_checker
bind refclk_select_and_irq_summary refclk_checker #(.STATUS_W(STATUS_W)) u_refclk_checker (.CLOCK, .SYS_RST,
   .WB_ADR_I, .WB_WE_I, .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O, .CHAN_IRQ_STATUS, .REFERENCE_CLOCK_OUTPUT_O,
   .REFERENCE_CLOCK_OUTPUT_OE, .AUX_CLOCK_RATE_SELECT);
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the reference clock and summary block
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, o, oe, rate, ack;
   logic [11:0]  adr = 0;
   logic [31:0]  wdat = 0, rdat;
   logic [7:0]   rd = 0;
   logic [16:0]  rec = 0;
   logic [135:0] st = 0;
   int           fail_count = 0, tests_run = 0, cycles = 0;
   always #20 clock = ~clock;
   refclk_select_and_irq_summary u_refclk_select_and_irq_summary (.CLOCK(clock), .SYS_RST(sys_rst),
      .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .RECOVERED_CLOCKS(rec), .CHAN_IRQ_STATUS(st),
      .REFERENCE_CLOCK_OUTPUT_O(o), .REFERENCE_CLOCK_OUTPUT_OE(oe), .AUX_CLOCK_RATE_SELECT(rate));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits for ack however long it takes; the cycle ceiling ends a hang
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
      do @(posedge clock); while (ack !== 1'b1);
      rd = rdat[7:0];
      {cyc, stb, we} <= 3'b000;
      @(posedge clock);
   endtask : bus
   task automatic t_ctrl;
      chk({7'h0, oe}, 8'h01);
      bus(0, 12'h020, 0);
      chk(rd, 8'h41);
      bus(1, 12'h020, 8'h21);
      repeat (2) @(posedge clock);
      chk({5'h0, oe, o, rate}, 8'h01);
      $display("control test done");
   endtask : t_ctrl
   task automatic t_src;
      for (int c = 0; c < 17; c++) begin
         bus(1, 12'h020, 8'h40 | 8'(c));
         rec <= 17'h1 << c;
         repeat (8) @(posedge clock);
         chk({6'h0, oe, o}, 8'h03);
         rec <= ~(17'h1 << c);
         repeat (8) @(posedge clock);
         chk({6'h0, oe, o}, 8'h02);
      end
      // Code past the last channel must drive low even with every clock high
      bus(1, 12'h020, 8'h51);
      rec <= '1;
      repeat (8) @(posedge clock);
      chk({6'h0, oe, o}, 8'h02);
      $display("source test done");
   endtask : t_src
   task automatic t_sum;
      logic [135:0] v = 136'hff;
      bus(0, 12'h2c0, 0);
      chk(rd, 8'h00);
      {v[19], v[64], v[87], v[129]} = 4'hf;
      st <= v;
      bus(1, 12'h2c0, 8'h00);
      bus(0, 12'h2c0, 0);
      chk(rd, 8'h82);
      bus(0, 12'h300, 0);
      chk(rd, 8'h82);
      st <= 0;
      // Summary lags the sources by one cycle
      @(posedge clock);
      bus(0, 12'h300, 0);
      chk(rd, 8'h00);
      bus(0, 12'h2c0, 0);
      chk(rd, 8'h00);
      $display("summary test done");
   endtask : t_sum
   task automatic t_rst;
      rec <= '0;
      bus(1, 12'h020, 8'h25);
      repeat (2) @(posedge clock);
      chk({5'h0, oe, o, rate}, 8'h01);
      sys_rst <= 1;
      repeat (6) @(posedge clock);
      chk({5'h0, oe, o, rate}, 8'h00);
      sys_rst <= 0;
      repeat (2) @(posedge clock);
      chk({5'h0, oe, o, rate}, 8'h04);
      bus(0, 12'h020, 0);
      chk(rd, 8'h41);
      $display("reset test done");
   endtask : t_rst
   task automatic wrap_up;
      $display("tests_run %0d fail_count %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : wrap_up
   // Generous ceiling; the full run needs well under 1000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         $display("mismatch at %0t: cycles %h limit %h", $time, cycles, 3000);
         wrap_up;
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      sys_rst <= 0;
      repeat (2) @(posedge clock);
      t_ctrl;
      t_src;
      t_sum;
      t_rst;
      wrap_up;
   end
endmodule : tb_top
`default_nettype wire
